// ===== hw/gpio_mux_pkg.sv
// Constants shared by the port block: register map, field positions, resets
package gpio_mux_pkg;
    // Bus shape
    localparam int WB_DATA_W = 32;
    localparam int WB_ADDR_W = 12;
    localparam int WB_WORD_SHIFT = 2;
    localparam int MIN_ADDR_W = 10;

    // Register indices; byte address is four times the index
    localparam logic [7:0] PORT_A_DATA = 8'hc0;
    localparam logic [7:0] PORT_A_DIR = 8'hc1;
    localparam logic [7:0] PORT_B_DATA = 8'hc2;
    localparam logic [7:0] PORT_B_DIR = 8'hc3;
    localparam logic [7:0] PORT_C_DATA = 8'hc4;
    localparam logic [7:0] PORT_C_DIR = 8'hc5;
    localparam logic [7:0] PORT_D_DATA = 8'hc6;
    localparam logic [7:0] PORT_D_DIR = 8'hc7;
    localparam logic [7:0] PORT_E_DATA = 8'hc8;
    localparam logic [7:0] PORT_E_DIR = 8'hc9;
    localparam logic [7:0] PORT_F_DATA = 8'hca;
    localparam logic [7:0] PORT_F_DIR = 8'hcb;
    localparam logic [7:0] PORT_G_DATA = 8'hcc;
    localparam logic [7:0] PORT_G_DIR = 8'hcd;
    localparam logic [7:0] PORT_H_DATA = 8'hce;
    localparam logic [7:0] PORT_H_DIR = 8'hcf;
    localparam logic [7:0] PORT_A_ALTSEL = 8'hf4;
    localparam logic [7:0] PORT_E_ALTSEL = 8'hf5;
    localparam logic [7:0] PORT_F_ALTSEL = 8'hf6;
    localparam logic [7:0] PORT_G_ALTSEL = 8'hf7;
    localparam logic [7:0] PORT_H_ALTSEL = 8'hf8;
    localparam int PORT_COUNT = 8;
    localparam int ALTSEL_COUNT = 5;

    // Port numbering inside the block
    localparam int PA = 0;
    localparam int PB = 1;
    localparam int PC = 2;
    localparam int PD = 3;
    localparam int PE = 4;
    localparam int PF = 5;
    localparam int PG = 6;
    localparam int PH = 7;

    // Alternate select register numbering
    localparam int SEL_A = 0;
    localparam int SEL_E = 1;
    localparam int SEL_F = 2;
    localparam int SEL_G = 3;
    localparam int SEL_H = 4;

    // Implemented bits of each port
    localparam logic [7:0] MASK_8 = 8'hff;
    localparam logic [7:0] MASK_6 = 8'h3f;
    localparam logic [7:0] MASK_4 = 8'h0f;

    // Field positions
    localparam int A_BUZZER_BIT = 3;
    localparam int A_EVENT_BIT = 2;
    localparam int A_IRQ1_BIT = 1;
    localparam int A_IRQ0_BIT = 0;
    localparam int E_TIMER0_BIT = 0;
    localparam int F_PULSE_BIT = 6;
    localparam int F_SDO_BIT = 5;
    localparam int F_SDI_BIT = 4;
    localparam int F_SCK_BIT = 3;
    localparam int ANALOG_COUNT = 12;
    localparam int ANALOG_HIGH_BASE = 8;

    // Reset values
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic [7:0] ALTSEL_RESET = 8'h00;

    // Implemented width mask of a port
    function automatic logic [7:0] port_mask(input int p);
        if (p == PD) begin
            return MASK_6;
        end
        if (p == PE || p == PH) begin
            return MASK_4;
        end
        return MASK_8;
    endfunction
endpackage

// ===== hw/gpio_ports_with_alt_function_mux.sv
// GPIO port block with data, direction and alternate function selection
`timescale 1ns/1ps
`default_nettype none

module gpio_ports_with_alt_function_mux #(
    parameter int ADDR_W = gpio_mux_pkg::WB_ADDR_W
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rstn,
    // Wishbone slave
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [ADDR_W-1:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    // Port pins
    input wire logic [7:0] i_port_a_pin,
    output logic [7:0] o_port_a_out,
    output logic [7:0] o_port_a_oe,
    input wire logic [7:0] i_port_b_pin,
    output logic [7:0] o_port_b_out,
    output logic [7:0] o_port_b_oe,
    input wire logic [7:0] i_port_c_pin,
    output logic [7:0] o_port_c_out,
    output logic [7:0] o_port_c_oe,
    input wire logic [5:0] i_port_d_pin,
    output logic [5:0] o_port_d_out,
    output logic [5:0] o_port_d_oe,
    input wire logic [3:0] i_port_e_pin,
    output logic [3:0] o_port_e_out,
    output logic [3:0] o_port_e_oe,
    input wire logic [7:0] i_port_f_pin,
    output logic [7:0] o_port_f_out,
    output logic [7:0] o_port_f_oe,
    input wire logic [7:0] i_port_g_pin,
    output logic [7:0] o_port_g_out,
    output logic [7:0] o_port_g_oe,
    input wire logic [3:0] i_port_h_pin,
    output logic [3:0] o_port_h_out,
    output logic [3:0] o_port_h_oe,
    // Peripheral outputs to pins
    input wire logic i_buzzer_output,
    input wire logic i_timer_zero_compare_out,
    input wire logic i_pulse_width_out,
    input wire logic i_timer_one_compare_out,
    input wire logic i_pulse_width_mode,
    input wire logic i_spi_serial_data_out,
    input wire logic i_spi_clock_out,
    // Pin levels to peripherals
    output logic o_event_count_input,
    output logic o_ext_irq_zero_input,
    output logic o_ext_irq_one_input,
    output logic o_spi_serial_data_in,
    output logic o_spi_clock_in,
    output logic o_spi_clock_is_input,
    // Analog channel routing
    input wire logic [3:0] i_converter_channel_code,
    output logic [11:0] o_analog_enable,
    output logic [11:0] o_analog_select,
    // Divided main clock
    input wire logic i_main_osc_input,
    output logic o_main_clk_half
);

    // Address space must reach the top register
    if (ADDR_W < gpio_mux_pkg::MIN_ADDR_W) begin : g_addr_check
        $error("ADDR_W too small for the register map");
    end

    // Register storage
    logic [7:0] latch [0:gpio_mux_pkg::PORT_COUNT-1];
    logic [7:0] dir [0:gpio_mux_pkg::PORT_COUNT-1];
    logic [7:0] altsel [0:gpio_mux_pkg::ALTSEL_COUNT-1];
    logic [7:0] pin_in [0:gpio_mux_pkg::PORT_COUNT-1];
    logic [7:0] drv_mask [0:gpio_mux_pkg::PORT_COUNT-1];
    logic [7:0] in_mask [0:gpio_mux_pkg::PORT_COUNT-1];
    logic [7:0] alt_val [0:gpio_mux_pkg::PORT_COUNT-1];
    logic [7:0] pin_out [0:gpio_mux_pkg::PORT_COUNT-1];
    logic [7:0] pin_oe [0:gpio_mux_pkg::PORT_COUNT-1];
    logic osc_seen;

    // Widen pin inputs to a common byte
    assign pin_in[gpio_mux_pkg::PA] = i_port_a_pin;
    assign pin_in[gpio_mux_pkg::PB] = i_port_b_pin;
    assign pin_in[gpio_mux_pkg::PC] = i_port_c_pin;
    assign pin_in[gpio_mux_pkg::PD] = {2'h0, i_port_d_pin};
    assign pin_in[gpio_mux_pkg::PE] = {4'h0, i_port_e_pin};
    assign pin_in[gpio_mux_pkg::PF] = i_port_f_pin;
    assign pin_in[gpio_mux_pkg::PG] = i_port_g_pin;
    assign pin_in[gpio_mux_pkg::PH] = {4'h0, i_port_h_pin};

    // Bus decode
    wire [7:0] reg_idx = i_wb_adr[gpio_mux_pkg::WB_WORD_SHIFT +: 8];
    wire addr_high_zero = (i_wb_adr >> (gpio_mux_pkg::WB_WORD_SHIFT + 8)) == '0;
    wire bus_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
    wire bus_wr = bus_req & i_wb_we & i_wb_sel[0] & addr_high_zero;
    wire [7:0] wr_byte = i_wb_dat[7:0];
    wire in_port_range = addr_high_zero && reg_idx >= gpio_mux_pkg::PORT_A_DATA
        && reg_idx <= gpio_mux_pkg::PORT_H_DIR;
    wire in_sel_range = addr_high_zero && reg_idx >= gpio_mux_pkg::PORT_A_ALTSEL
        && reg_idx <= gpio_mux_pkg::PORT_H_ALTSEL;
    wire [7:0] port_off = reg_idx - gpio_mux_pkg::PORT_A_DATA;
    wire [7:0] sel_off = reg_idx - gpio_mux_pkg::PORT_A_ALTSEL;
    wire [2:0] port_num = port_off[3:1];
    wire is_dir = port_off[0];

    // Read selection: data reads sample pins, not the latch
    wire [7:0] port_rd = is_dir ? dir[port_num] : pin_in[port_num];
    wire [7:0] rd_byte = in_port_range ? (port_rd & gpio_mux_pkg::port_mask(int'(port_num)))
        : in_sel_range ? altsel[sel_off[2:0]] : 8'h00;

    // Bus answer, one cycle after the request; unmapped reads return zero
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_wb_ack <= 1'h0;
            o_wb_dat <= 32'h0;
        end else begin
            o_wb_ack <= bus_req;
            if (bus_req) begin
                o_wb_dat <= {24'h0, rd_byte};
            end
        end
    end

    // Latch and direction registers, one pair per port at adjacent indices
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            for (int p = 0; p < gpio_mux_pkg::PORT_COUNT; p++) begin
                latch[p] <= gpio_mux_pkg::LATCH_RESET;
                dir[p] <= gpio_mux_pkg::DIR_RESET;
            end
        end else if (bus_wr && in_port_range) begin
            for (int p = 0; p < gpio_mux_pkg::PORT_COUNT; p++) begin
                if (int'(port_num) == p && !is_dir) begin
                    latch[p] <= wr_byte & gpio_mux_pkg::port_mask(p);
                end
                if (int'(port_num) == p && is_dir) begin
                    dir[p] <= wr_byte & gpio_mux_pkg::port_mask(p);
                end
            end
        end
    end

    // Alternate function select registers
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            for (int s = 0; s < gpio_mux_pkg::ALTSEL_COUNT; s++) begin
                altsel[s] <= gpio_mux_pkg::ALTSEL_RESET;
            end
        end else if (bus_wr && in_sel_range) begin
            for (int s = 0; s < gpio_mux_pkg::ALTSEL_COUNT; s++) begin
                if (int'(sel_off) == s) begin
                    altsel[s] <= wr_byte;
                end
            end
        end
    end

    // Shorthand for the select registers
    wire [7:0] sel_a = altsel[gpio_mux_pkg::SEL_A];
    wire [7:0] sel_e = altsel[gpio_mux_pkg::SEL_E];
    wire [7:0] sel_f = altsel[gpio_mux_pkg::SEL_F];
    wire [7:0] sel_g = altsel[gpio_mux_pkg::SEL_G];
    wire [7:0] sel_h = altsel[gpio_mux_pkg::SEL_H];
    wire sck_sel = sel_f[gpio_mux_pkg::F_SCK_BIT];
    wire sck_dir = dir[gpio_mux_pkg::PF][gpio_mux_pkg::F_SCK_BIT];
    wire pulse_src = i_pulse_width_mode ? i_pulse_width_out : i_timer_one_compare_out;

    // Port A: buzzer drives, event and interrupt pins are forced inputs
    assign drv_mask[gpio_mux_pkg::PA] = {4'h0, sel_a[gpio_mux_pkg::A_BUZZER_BIT], 3'h0};
    assign in_mask[gpio_mux_pkg::PA] = {5'h0, sel_a[2:0]};
    assign alt_val[gpio_mux_pkg::PA] = {4'h0, i_buzzer_output, 3'h0};

    // Ports B, C, D: plain I/O
    assign drv_mask[gpio_mux_pkg::PB] = 8'h00;
    assign in_mask[gpio_mux_pkg::PB] = 8'h00;
    assign alt_val[gpio_mux_pkg::PB] = 8'h00;
    assign drv_mask[gpio_mux_pkg::PC] = 8'h00;
    assign in_mask[gpio_mux_pkg::PC] = 8'h00;
    assign alt_val[gpio_mux_pkg::PC] = 8'h00;
    assign drv_mask[gpio_mux_pkg::PD] = 8'h00;
    assign in_mask[gpio_mux_pkg::PD] = 8'h00;
    assign alt_val[gpio_mux_pkg::PD] = 8'h00;

    // Port E: timer zero compare on pin zero
    assign drv_mask[gpio_mux_pkg::PE] = {7'h0, sel_e[gpio_mux_pkg::E_TIMER0_BIT]};
    assign in_mask[gpio_mux_pkg::PE] = 8'h00;
    assign alt_val[gpio_mux_pkg::PE] = {7'h0, i_timer_zero_compare_out};

    // Port F: pulse/timer out, SPI pins; clock role set by its direction bit
    assign drv_mask[gpio_mux_pkg::PF] = {1'h0, sel_f[gpio_mux_pkg::F_PULSE_BIT],
        sel_f[gpio_mux_pkg::F_SDO_BIT], 1'h0, sck_sel & ~sck_dir, 3'h0};
    assign in_mask[gpio_mux_pkg::PF] = {3'h0, sel_f[gpio_mux_pkg::F_SDI_BIT],
        sck_sel & sck_dir, 3'h0};
    assign alt_val[gpio_mux_pkg::PF] = {1'h0, pulse_src, i_spi_serial_data_out, 1'h0,
        i_spi_clock_out, 3'h0};

    // Ports G and H: analog inputs, never driven while selected
    assign drv_mask[gpio_mux_pkg::PG] = 8'h00;
    assign in_mask[gpio_mux_pkg::PG] = sel_g;
    assign alt_val[gpio_mux_pkg::PG] = 8'h00;
    assign drv_mask[gpio_mux_pkg::PH] = 8'h00;
    assign in_mask[gpio_mux_pkg::PH] = {4'h0, sel_h[3:0]};
    assign alt_val[gpio_mux_pkg::PH] = 8'h00;

    // Pin drive: latch where direction is one, alternate value where forced
    for (genvar p = 0; p < gpio_mux_pkg::PORT_COUNT; p++) begin : g_pin
        assign pin_out[p] = ((latch[p] & ~drv_mask[p]) | (alt_val[p] & drv_mask[p]))
            & gpio_mux_pkg::port_mask(p);
        assign pin_oe[p] = ((dir[p] & ~in_mask[p] & ~drv_mask[p]) | drv_mask[p])
            & gpio_mux_pkg::port_mask(p);
    end

    // Pin outputs
    assign o_port_a_out = pin_out[gpio_mux_pkg::PA];
    assign o_port_a_oe = pin_oe[gpio_mux_pkg::PA];
    assign o_port_b_out = pin_out[gpio_mux_pkg::PB];
    assign o_port_b_oe = pin_oe[gpio_mux_pkg::PB];
    assign o_port_c_out = pin_out[gpio_mux_pkg::PC];
    assign o_port_c_oe = pin_oe[gpio_mux_pkg::PC];
    assign o_port_d_out = pin_out[gpio_mux_pkg::PD][5:0];
    assign o_port_d_oe = pin_oe[gpio_mux_pkg::PD][5:0];
    assign o_port_e_out = pin_out[gpio_mux_pkg::PE][3:0];
    assign o_port_e_oe = pin_oe[gpio_mux_pkg::PE][3:0];
    assign o_port_f_out = pin_out[gpio_mux_pkg::PF];
    assign o_port_f_oe = pin_oe[gpio_mux_pkg::PF];
    assign o_port_g_out = pin_out[gpio_mux_pkg::PG];
    assign o_port_g_oe = pin_oe[gpio_mux_pkg::PG];
    assign o_port_h_out = pin_out[gpio_mux_pkg::PH][3:0];
    assign o_port_h_oe = pin_oe[gpio_mux_pkg::PH][3:0];

    // Analog channel enables and the channel picked by the converter code
    wire [11:0] next_analog_enable = {sel_h[3:0], sel_g};
    logic [11:0] next_analog_select;
    always_comb begin
        next_analog_select = 12'h000;
        for (int n = 0; n < gpio_mux_pkg::ANALOG_COUNT; n++) begin
            next_analog_select[n] = next_analog_enable[n]
                && (int'(i_converter_channel_code) == n);
        end
    end

    // Pin levels handed to peripherals, zero unless the function is selected
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_event_count_input <= 1'h0;
            o_ext_irq_zero_input <= 1'h0;
            o_ext_irq_one_input <= 1'h0;
            o_spi_serial_data_in <= 1'h0;
            o_spi_clock_in <= 1'h0;
            o_spi_clock_is_input <= 1'h0;
            o_analog_enable <= 12'h000;
            o_analog_select <= 12'h000;
        end else begin
            o_event_count_input <= sel_a[gpio_mux_pkg::A_EVENT_BIT] & i_port_a_pin[2];
            o_ext_irq_zero_input <= sel_a[gpio_mux_pkg::A_IRQ0_BIT] & i_port_a_pin[0];
            o_ext_irq_one_input <= sel_a[gpio_mux_pkg::A_IRQ1_BIT] & i_port_a_pin[1];
            o_spi_serial_data_in <= sel_f[gpio_mux_pkg::F_SDI_BIT] & i_port_f_pin[4];
            o_spi_clock_in <= sck_sel & sck_dir & i_port_f_pin[3];
            o_spi_clock_is_input <= sck_sel & sck_dir;
            o_analog_enable <= next_analog_enable;
            o_analog_select <= next_analog_select;
        end
    end

    // Divide-by-two of the oscillator input, edge found on the core clock
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            osc_seen <= 1'h0;
            o_main_clk_half <= 1'h0;
        end else begin
            osc_seen <= i_main_osc_input;
            if (i_main_osc_input && !osc_seen) begin
                o_main_clk_half <= ~o_main_clk_half;
            end
        end
    end

endmodule

`default_nettype wire

// ===== tb/pin_pad_model.sv
// Board-side model of one port's pins
`timescale 1ns/1ps
`default_nettype none
module pin_pad_model #(
    parameter int W = 8
) (
    // Block side
    input wire logic [W-1:0] i_oe,
    input wire logic [W-1:0] i_out,
    // Board side
    input wire logic [W-1:0] i_ext,
    output logic [W-1:0] o_pin
);
    // Driven bits follow the block, released bits follow the board
    assign o_pin = (i_oe & i_out) | (~i_oe & i_ext);
endmodule
`default_nettype wire

// ===== tb/gpio_mux_chk.sv
// Assertion checker for the port block
`timescale 1ns/1ps
`default_nettype none
module gpio_mux_chk #(
    parameter int ADDR_W = 12
) (
    // Clock, reset and bus
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [ADDR_W-1:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    input wire logic [31:0] o_wb_dat,
    input wire logic o_wb_ack,
    // Pins and peripherals
    input wire logic [7:0] i_port_a_pin,
    input wire logic [7:0] o_port_a_out,
    input wire logic [7:0] o_port_a_oe,
    input wire logic [7:0] o_port_b_oe,
    input wire logic [3:0] o_port_e_out,
    input wire logic [3:0] o_port_e_oe,
    input wire logic [7:0] o_port_f_oe,
    input wire logic [7:0] o_port_g_oe,
    input wire logic [3:0] o_port_h_oe,
    input wire logic i_buzzer_output,
    input wire logic i_timer_zero_compare_out,
    input wire logic o_spi_clock_is_input,
    input wire logic [3:0] i_converter_channel_code,
    input wire logic [11:0] o_analog_enable,
    input wire logic [11:0] o_analog_select,
    input wire logic o_main_clk_half
);
    // Request decode
    wire logic take = i_wb_cyc && i_wb_stb && !o_wb_ack;
    wire logic [7:0] idx = i_wb_adr[9:2];
    wire logic wr = take && i_wb_we && i_wb_sel[0] && ((i_wb_adr >> 10) == 0);
    wire logic rd_a = take && !i_wb_we && ((i_wb_adr >> 10) == 0) && idx == gpio_mux_pkg::PORT_A_DATA;
    logic [1:0] up;

    // Cycles since reset, saturating
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            up <= 2'd0;
        end else if (up != 2'd3) begin
            up <= up + 2'd1;
        end
    end

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);

    // Multi-step behaviours
    sequence s_ack_once;
        o_wb_ack ##1 !o_wb_ack;
    endsequence
    sequence s_pin_steady;
        $stable(i_port_a_pin) [*3];
    endsequence

    AST_ACK_ONCE: assert property (take |=> s_ack_once)
        else $error("ack is not one pulse after a request");
    AST_RESET_IDLE: assert property ($rose(i_rstn) |-> !o_wb_ack && o_analog_enable == 12'h000
        && {o_port_a_oe, o_port_b_oe, o_port_e_oe, o_port_f_oe, o_port_g_oe, o_port_h_oe} == 40'h0)
        else $error("pin driven or select set after reset");
    AST_DIR_B: assert property (wr && idx == gpio_mux_pkg::PORT_B_DIR |=> o_port_b_oe == $past(i_wb_dat[7:0]))
        else $error("port B drive enable differs from direction written");
    AST_READ_PIN: assert property ((s_pin_steady ##0 (rd_a && up == 2'd3))
        |=> o_wb_dat == {24'h0, $past(i_port_a_pin)})
        else $error("port A read does not return pin levels");
    AST_BUZZER: assert property (wr && idx == gpio_mux_pkg::PORT_A_ALTSEL && i_wb_dat[3]
        |=> o_port_a_oe[3] && o_port_a_out[3] == i_buzzer_output)
        else $error("buzzer not driven on port A pin 3");
    AST_TIMER0: assert property (wr && idx == gpio_mux_pkg::PORT_E_ALTSEL && i_wb_dat[0]
        |=> o_port_e_oe[0] && o_port_e_out[0] == i_timer_zero_compare_out)
        else $error("timer zero compare not driven on port E pin 0");
    AST_SCK_ROLE: assert property (o_spi_clock_is_input |-> !$past(o_port_f_oe[3]))
        else $error("SPI clock input while pin was driven");
    AST_ANALOG_SEL: assert property (o_analog_select ==
        (o_analog_enable & (12'h001 << $past(i_converter_channel_code))))
        else $error("analog select does not match channel code");
    AST_ANALOG_OE: assert property ((o_analog_enable & {$past(o_port_h_oe), $past(o_port_g_oe)}) == 12'h000)
        else $error("analog pin still driven");
    AST_HALF: assert property ($changed(o_main_clk_half) |=> $stable(o_main_clk_half))
        else $error("divided clock toggled twice in a row");
endmodule
bind gpio_ports_with_alt_function_mux gpio_mux_chk #(.ADDR_W(ADDR_W)) u_chk (.*);
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the port block
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam logic [7:0] MSK [8] = '{8'hff, 8'hff, 8'hff, 8'h3f, 8'h0f, 8'hff, 8'hff, 8'h0f};
    logic clk, rstn, cyc, stb, we, buzz, t0, pulse, t1, pmode, sdo, sck, osc, hp;
    logic [11:0] adr;
    logic [3:0] sel, code;
    logic [31:0] dat;
    logic [7:0] ext [8];
    logic [7:0] r;
    wire [7:0] oe [8];
    wire [7:0] out [8];
    wire [7:0] pin [8];
    wire [31:0] q;
    wire ack, ev, irq0, irq1, sdi, scki, sckin, half;
    wire [11:0] aen, asel;
    int fail_count = 0;
    int comparisons = 0;

    // Design and board pins
    gpio_ports_with_alt_function_mux u_dut (
        .i_core_clk(clk), .i_rstn(rstn), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
        .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(dat), .o_wb_dat(q), .o_wb_ack(ack),
        .i_port_a_pin(pin[0]), .o_port_a_out(out[0]), .o_port_a_oe(oe[0]),
        .i_port_b_pin(pin[1]), .o_port_b_out(out[1]), .o_port_b_oe(oe[1]),
        .i_port_c_pin(pin[2]), .o_port_c_out(out[2]), .o_port_c_oe(oe[2]),
        .i_port_d_pin(pin[3][5:0]), .o_port_d_out(out[3][5:0]), .o_port_d_oe(oe[3][5:0]),
        .i_port_e_pin(pin[4][3:0]), .o_port_e_out(out[4][3:0]), .o_port_e_oe(oe[4][3:0]),
        .i_port_f_pin(pin[5]), .o_port_f_out(out[5]), .o_port_f_oe(oe[5]),
        .i_port_g_pin(pin[6]), .o_port_g_out(out[6]), .o_port_g_oe(oe[6]),
        .i_port_h_pin(pin[7][3:0]), .o_port_h_out(out[7][3:0]), .o_port_h_oe(oe[7][3:0]),
        .i_buzzer_output(buzz), .i_timer_zero_compare_out(t0), .i_pulse_width_out(pulse),
        .i_timer_one_compare_out(t1), .i_pulse_width_mode(pmode), .i_spi_serial_data_out(sdo),
        .i_spi_clock_out(sck), .o_event_count_input(ev), .o_ext_irq_zero_input(irq0),
        .o_ext_irq_one_input(irq1), .o_spi_serial_data_in(sdi), .o_spi_clock_in(scki),
        .o_spi_clock_is_input(sckin), .i_converter_channel_code(code), .o_analog_enable(aen),
        .o_analog_select(asel), .i_main_osc_input(osc), .o_main_clk_half(half)
    );
    for (genvar g = 0; g < 8; g++) begin : g_pad
        pin_pad_model u_pad (.i_oe(oe[g]), .i_out(out[g]), .i_ext(ext[g]), .o_pin(pin[g]));
    end

    // Closing report
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Compare seen against expected
    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One classic bus cycle, held until ack
    task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d, input logic s);
        @(posedge clk);
        {cyc, stb, we, sel, adr, dat} <= {2'b11, w, 3'b000, s, 2'b00, i, 2'b00, 24'h0, d};
        // Wait for ack however long; only the watchdog ends a hang
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        r = q[7:0];
        {cyc, stb} <= 2'b00;
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        bus(1'b1, i, d, 1'b1);
    endtask
    task automatic rd(input logic [7:0] i, input logic [7:0] e);
        bus(1'b0, i, 8'h00, 1'b1);
        chk(r, e);
    endtask
    task automatic settle;
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask

    // Expected pin level and latch pattern
    function automatic logic [7:0] lvl(input logic [7:0] o, input logic [7:0] v, input logic [7:0] x);
        return (o & v) | (~o & x);
    endfunction
    function automatic logic [7:0] lat(input int p);
        return 8'ha3 ^ 8'(p);
    endfunction

    // Clock and watchdog
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        give_verdict();
    end

    // Main sequence
    initial begin
        {rstn, cyc, stb, we, sel, adr, dat, buzz, t0, pulse, t1, pmode, sdo, sck, osc, code} = '0;
        for (int p = 0; p < 8; p++) begin
            ext[p] = 8'h3c + 8'(p * 37);
        end
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        settle();
        for (int p = 0; p < 8; p++) begin
            chk(oe[p] & MSK[p], 0);
            rd(8'hc0 + 8'(2 * p), ext[p] & MSK[p]);
            rd(8'hc1 + 8'(2 * p), 8'h00);
        end
        for (int k = 0; k < 5; k++) begin
            rd(8'hf4 + 8'(k), 8'h00);
        end
        // Latch and direction on every port
        for (int p = 0; p < 8; p++) begin
            ext[p] <= ~ext[p];
            wr(8'hc0 + 8'(2 * p), lat(p));
            wr(8'hc1 + 8'(2 * p), 8'h55);
            settle();
            chk(oe[p] & MSK[p], 8'h55 & MSK[p]);
            chk(out[p] & oe[p] & MSK[p], lat(p) & 8'h55 & MSK[p]);
            rd(8'hc0 + 8'(2 * p), lvl(8'h55, lat(p), ext[p]) & MSK[p]);
            rd(8'hc1 + 8'(2 * p), 8'h55 & MSK[p]);
        end
        // Port A and E alternate pins override direction
        wr(gpio_mux_pkg::PORT_A_ALTSEL, 8'h0f);
        wr(gpio_mux_pkg::PORT_E_DIR, 8'h00);
        wr(gpio_mux_pkg::PORT_E_ALTSEL, 8'h01);
        ext[0] <= 8'h05;
        for (int v = 0; v < 2; v++) begin
            @(posedge clk);
            {buzz, t0} <= {v[0], v[0]};
            settle();
            chk({oe[0][3:0], out[0][3], oe[4][3:0], out[4][0]}, {4'h8, v[0], 4'h1, v[0]});
        end
        chk({ev, irq1, irq0}, 3'b101);
        rd(gpio_mux_pkg::PORT_A_DATA, lvl(8'h58, lat(0) | 8'h08, 8'h05));
        wr(gpio_mux_pkg::PORT_A_ALTSEL, 8'h00);
        settle();
        chk({oe[0], out[0]}, {8'h55, lat(0)});
        // Port F peripheral pins
        wr(gpio_mux_pkg::PORT_F_ALTSEL, 8'h78);
        for (int v = 0; v < 4; v++) begin
            @(posedge clk);
            {pmode, pulse, t1, sdo, sck} <= {v[0], v[1], !v[1], v[1], v[0]};
            ext[5] <= {3'b000, v[1], 4'h0};
            settle();
            chk({oe[5][6:3], out[5][6:5], out[5][3], sdi}, {4'hd, v[0] ? v[1] : !v[1], v[1], v[0], v[1]});
        end
        @(posedge clk);
        ext[5] <= 8'h08;
        wr(gpio_mux_pkg::PORT_F_DIR, 8'h08);
        settle();
        chk({oe[5][3], sckin, scki}, 3'b011);
        // Analog pins follow the channel code
        wr(gpio_mux_pkg::PORT_G_ALTSEL, 8'hff);
        wr(gpio_mux_pkg::PORT_H_ALTSEL, 8'h0f);
        for (int c = 0; c < 16; c++) begin
            @(posedge clk);
            code <= 4'(c);
            settle();
            chk({oe[7][3:0], oe[6], aen, asel}, {12'h0, 12'hfff, (c < 12) ? 12'h001 << c : 12'h0});
        end
        // Unmapped place and disabled byte lane
        rd(8'hd0, 8'h00);
        bus(1'b1, gpio_mux_pkg::PORT_B_DIR, 8'hff, 1'b0);
        rd(gpio_mux_pkg::PORT_B_DIR, 8'h55);
        // Oscillator divider: eight rising edges
        // Count toggles of the divided clock between consecutive edges
        r = 0;
        hp = half;
        for (int i = 0; i < 80; i++) begin
            @(posedge clk);
            osc <= (i < 64) && i[2];
            r = r + 8'(half !== hp);
            hp = half;
        end
        chk({r, 7'h0, hp}, {8'd8, 8'h00});
        // Second reset mid-run
        rstn <= 1'b0;
        settle();
        chk({oe[0], oe[5], aen}, 0);
        @(posedge clk);
        rstn <= 1'b1;
        settle();
        rd(gpio_mux_pkg::PORT_F_DIR, 8'h00);
        rd(gpio_mux_pkg::PORT_G_ALTSEL, 8'h00);
        give_verdict();
    end
endmodule
`default_nettype wire
